/* rtl/rxs_pkg.sv */
// Overview of operation
// - A read-only 16-bit status register mirrors the status word of the frame at the head of the receive queue.
// - The frame-valid flag (bit 15) is set whenever the queue holds a status word; one is written at every accepted end beat with room, even outside a frame.
// - The frame-valid flag reads clear when no frame is pending or the only frame is still arriving.
// - The ingress port field (bits 9-8) reads 01 for port 1 and 10 for port 2, and 00 while no frame is pending.
// - Bit 7 is set when the destination address is the broadcast address.
// - Bit 6 is set for any group (multicast) destination, broadcast included.
// - Bit 5 is set when the destination address is an individual (unicast) address.
// - Bit 3 is set when the length/type field exceeds 1500 and clear otherwise.
// - Bit 3 has no meaning for runt frames; the device forces it clear and the host ignores it.
// - The oversize flag (bit 2) is set when the frame is longer than 1916 bytes.
// - The oversize flag only reports length; the frame is never truncated.
// - Oversize frames reach the host queue only when pass-bad-frame (control bit 9) is set, else they are dropped.
// - The runt flag (bit 1) is set for frames hit by a collision at any point or ended early inside the collision window.
// - Runt frames reach the host queue only when pass-bad-frame is set, else they are dropped.
// - The CRC-error flag (bit 0) is set when the frame check sequence of the frame failed.
// - CRC-error frames reach the host queue only when pass-bad-frame is set, else they are dropped.
package rxs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port geometry and byte offsets
  localparam int RXS_ADDR_W = 8;
  localparam int RXS_DATA_W = 16;
  localparam logic [7:0] RXS_OFS_CONTROL = 8'h00;
  localparam logic [7:0] RXS_OFS_STATUS = 8'h04;
  localparam logic [7:0] RXS_OFS_EVENT = 8'h08;
  localparam logic [7:0] RXS_OFS_MASK = 8'h0C;
  localparam logic [7:0] RXS_OFS_RELEASE = 8'h10;

  // Control register fields and reset value
  localparam int RXS_CTL_PASS_BAD = 9;
  localparam logic [15:0] RXS_CTL_RESET = 16'h0000;
  localparam logic [15:0] RXS_CTL_MASK = 16'h0200;
  localparam int RXS_REL_POP = 0;

  // Event bits: frame queued, frame dropped, queue overrun
  localparam int RXS_EVT_W = 3;
  localparam int RXS_EVT_QUEUED = 0;
  localparam int RXS_EVT_DROPPED = 1;
  localparam int RXS_EVT_OVERRUN = 2;
  localparam logic [2:0] RXS_EVT_RESET = 3'h0;

  // Frame limits in bytes: 1916 oversize, 1500 type threshold, 64 collision window
  localparam logic [15:0] RXS_MAX_LEN = 16'h077C;
  localparam logic [15:0] RXS_TYPE_MIN = 16'h05DC;
  localparam logic [15:0] RXS_MIN_LEN = 16'h0040;
  localparam logic [15:0] RXS_DA_BYTES = 16'h0006;
  localparam logic [15:0] RXS_TYPE_HI_POS = 16'h000C;
  localparam logic [15:0] RXS_TYPE_LO_POS = 16'h000D;
  localparam logic [15:0] RXS_CNT_MAX = 16'hFFFF;
  localparam logic [7:0] RXS_BCAST_BYTE = 8'hFF;

  // Ingress port codes
  localparam logic [1:0] RXS_PORT_ONE = 2'h1;
  localparam logic [1:0] RXS_PORT_TWO = 2'h2;

  // Host queue of status words
  localparam int RXS_Q_DEPTH = 4;
  localparam int RXS_PTR_W = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic frame_valid_flag;
    logic [4:0] rsvd_hi;
    logic [1:0] ingress_port_field;
    logic broadcast_flag;
    logic group_address_flag;
    logic individual_address_flag;
    logic rsvd_4;
    logic frame_type_flag;
    logic oversize_flag;
    logic short_frame_flag;
    logic fcs_error_flag;
  } rxs_status_t;

  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [7:0] data;
    logic port_two;
    logic abort;
    logic fcs_bad;
  } rxs_beat_t;

  typedef struct packed {
    logic [RXS_ADDR_W-1:0] addr;
    logic [RXS_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rxs_bus_t;

  typedef enum logic [1:0] {
    RXS_ST_IDLE = 2'b01,
    RXS_ST_RECV = 2'b10
  } rxs_state_t;

endpackage

/* rtl/rxs_frame_status.sv */
// Added by the designer: the strobed register port.
module rxs_frame_status
  import rxs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Receive beats from the switch MAC ports
  input wire rxs_beat_t rx_beat,
  // Host register port
  input wire rxs_bus_t host_bus,
  output logic [RXS_DATA_W-1:0] rd_data,
  // Interrupt and drop indication
  output logic irq,
  output logic frame_dropped
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  rxs_state_t state;
  rxs_state_t next_state;
  logic [15:0] byte_cnt;
  logic bcast_run;
  logic group_bit;
  logic [7:0] type_hi;
  logic [15:0] type_val;
  logic port_two_q;
  logic abort_q;
  logic [15:0] control;
  logic [RXS_EVT_W-1:0] evt_status;
  logic [RXS_EVT_W-1:0] evt_mask;
  rxs_status_t status_mem [RXS_Q_DEPTH];
  logic [RXS_PTR_W:0] wr_ptr;
  logic [RXS_PTR_W:0] rd_ptr;

  logic [15:0] cur_cnt;
  logic [15:0] cur_pos;
  logic cur_bcast;
  logic cur_group;
  logic cur_port_two;
  logic [15:0] cur_type;
  logic cur_abort;
  logic frame_end;
  rxs_status_t new_status;
  logic frame_bad;
  logic frame_accept;
  logic q_empty;
  logic q_full;
  logic do_push;
  logic do_pop;
  logic ev_queued;
  logic ev_dropped;
  logic ev_overrun;
  rxs_status_t head_view;
  logic wr_control;
  logic wr_event;
  logic wr_mask;
  logic wr_release;

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode; the status offset has no write decode at all
  assign wr_control = host_bus.wr && (host_bus.addr == RXS_OFS_CONTROL);
  assign wr_event = host_bus.wr && (host_bus.addr == RXS_OFS_EVENT);
  assign wr_mask = host_bus.wr && (host_bus.addr == RXS_OFS_MASK);
  assign wr_release = host_bus.wr && (host_bus.addr == RXS_OFS_RELEASE);

  ////////////////////////////////////////////////////////////////////////////
  // Running view of the frame including the beat now on the input
  always_comb begin
    cur_cnt = 16'h0001;
    if (!rx_beat.sof) begin
      // Saturate so a runaway frame still reads as oversize
      cur_cnt = (byte_cnt == RXS_CNT_MAX) ? byte_cnt : byte_cnt + 16'h0001;
    end
    cur_pos = cur_cnt - 16'h0001;
    cur_bcast = rx_beat.sof ? 1'b1 : bcast_run;
    if (cur_pos < RXS_DA_BYTES) begin
      cur_bcast = cur_bcast && (rx_beat.data == RXS_BCAST_BYTE);
    end
    // Group bit is the first bit on the wire of the first address byte
    cur_group = (cur_pos == 16'h0000) ? rx_beat.data[0] : group_bit;
    cur_port_two = rx_beat.sof ? rx_beat.port_two : port_two_q;
    cur_type = (cur_pos == RXS_TYPE_LO_POS) ? {type_hi, rx_beat.data} : type_val;
    cur_abort = (rx_beat.sof ? 1'b0 : abort_q) || rx_beat.abort;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word built at the end of a frame
  always_comb begin
    new_status = '0;
    new_status.frame_valid_flag = 1'b1;
    new_status.ingress_port_field = cur_port_two ? RXS_PORT_TWO : RXS_PORT_ONE;
    new_status.broadcast_flag = cur_bcast && (cur_cnt >= RXS_DA_BYTES);
    new_status.group_address_flag = cur_group;
    new_status.individual_address_flag = !cur_group;
    new_status.oversize_flag = cur_cnt > RXS_MAX_LEN;
    // A collision at any point, or an early end inside the collision window, makes a runt
    new_status.short_frame_flag = cur_abort || (cur_cnt < RXS_MIN_LEN);
    new_status.fcs_error_flag = rx_beat.fcs_bad;
    // Type is left clear on runts since the field may never have arrived
    new_status.frame_type_flag = !new_status.short_frame_flag && (cur_type > RXS_TYPE_MIN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance: bad frames pass only with pass-bad-frame set
  assign frame_end = rx_beat.valid && rx_beat.eof;
  assign frame_bad = new_status.oversize_flag || new_status.short_frame_flag || new_status.fcs_error_flag;
  assign frame_accept = !frame_bad || control[RXS_CTL_PASS_BAD];
  assign q_empty = (wr_ptr == rd_ptr);
  assign q_full = (wr_ptr[RXS_PTR_W] != rd_ptr[RXS_PTR_W]) &&
                  (wr_ptr[RXS_PTR_W-1:0] == rd_ptr[RXS_PTR_W-1:0]);
  assign do_pop = wr_release && host_bus.wdata[RXS_REL_POP] && !q_empty;
  // A full queue frees its head slot this same cycle when popped
  assign do_push = frame_end && frame_accept && (!q_full || do_pop);
  assign ev_queued = do_push;
  assign ev_dropped = frame_end && !frame_accept;
  assign ev_overrun = frame_end && frame_accept && q_full && !do_pop;

  ////////////////////////////////////////////////////////////////////////////
  // Receive sequencer: a start beat always opens a new frame
  always_comb begin
    next_state = state;
    case (state)
      RXS_ST_IDLE: begin
        if (rx_beat.valid && rx_beat.sof && !rx_beat.eof) begin
          next_state = RXS_ST_RECV;
        end
      end
      RXS_ST_RECV: begin
        if (rx_beat.valid && rx_beat.eof) begin
          next_state = RXS_ST_IDLE;
        end
      end
      default: begin
        next_state = RXS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= RXS_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-frame parse state; beats outside a frame are ignored
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      byte_cnt <= 16'h0000;
      bcast_run <= 1'b0;
      group_bit <= 1'b0;
      port_two_q <= 1'b0;
      abort_q <= 1'b0;
    end else if (rx_beat.valid && (rx_beat.sof || state == RXS_ST_RECV)) begin
      byte_cnt <= cur_cnt;
      bcast_run <= cur_bcast;
      group_bit <= cur_group;
      port_two_q <= cur_port_two;
      abort_q <= cur_abort;
    end
  end

  // Length/type capture; cleared on start so short frames never see stale type
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      type_hi <= 8'h00;
      type_val <= 16'h0000;
    end else if (rx_beat.valid && rx_beat.sof) begin
      type_hi <= 8'h00;
      type_val <= 16'h0000;
    end else if (rx_beat.valid && state == RXS_ST_RECV) begin
      if (cur_pos == RXS_TYPE_HI_POS) begin
        type_hi <= rx_beat.data;
      end
      type_val <= cur_type;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host queue of status words; written at every accepted end beat with room in the queue, including an end beat outside a frame
  always_ff @(posedge mclk) begin
    if (do_push) begin
      status_mem[wr_ptr[RXS_PTR_W-1:0]] <= new_status;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // Head view: zero while nothing complete is pending
  always_comb begin
    head_view = '0;
    if (!q_empty) begin
      head_view = status_mem[rd_ptr[RXS_PTR_W-1:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register: only pass-bad-frame is implemented
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      control <= RXS_CTL_RESET;
    end else if (wr_control) begin
      control <= host_bus.wdata & RXS_CTL_MASK;
    end
  end

  // Event flags: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evt_status <= RXS_EVT_RESET;
    end else begin
      evt_status <= (evt_status & ~(wr_event ? host_bus.wdata[RXS_EVT_W-1:0] : RXS_EVT_RESET))
                    | {ev_overrun, ev_dropped, ev_queued};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evt_mask <= RXS_EVT_RESET;
    end else if (wr_mask) begin
      evt_mask <= host_bus.wdata[RXS_EVT_W-1:0];
    end
  end

  // Interrupt level follows the flags one cycle later
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status & evt_mask);
    end
  end

  // Drop pulse for the switch statistics
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      frame_dropped <= 1'b0;
    end else begin
      frame_dropped <= ev_dropped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data stands one cycle after the strobe and is zero otherwise
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= '0;
      if (host_bus.rd) begin
        case (host_bus.addr)
          RXS_OFS_CONTROL: rd_data <= control;
          RXS_OFS_STATUS: rd_data <= head_view;
          RXS_OFS_EVENT: rd_data <= {{(RXS_DATA_W-RXS_EVT_W){1'b0}}, evt_status};
          RXS_OFS_MASK: rd_data <= {{(RXS_DATA_W-RXS_EVT_W){1'b0}}, evt_mask};
          default: rd_data <= '0;
        endcase
      end
    end
  end

endmodule

/* verif/rxs_mac_model.sv */
module rxs_mac_model
  import rxs_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Beats toward the block
  output rxs_beat_t rx_beat
);
  timeunit 1ns;
  timeprecision 1ns;

  initial rx_beat = '0;

  // One frame: DA pattern, length/type at bytes 12-13, optional idle gap after each beat
  task automatic send(input logic [7:0] da, input logic p2, input int len, input logic [15:0] typ,
                      input logic ab, input logic fb, input logic slow);
    logic [7:0] b;
    for (int i = 0; i < len; i++) begin
      b = (i < 6) ? da : (i == 12) ? typ[15:8] : (i == 13) ? typ[7:0] : 8'(i);
      @(posedge mclk);
      rx_beat <= '{valid:1'b1, sof:(i == 0), eof:(i == len - 1), data:b, port_two:p2, abort:ab,
                   fcs_bad:fb && (i == len - 1)};
      if (slow && i < len - 1) begin
        @(posedge mclk);
        rx_beat <= '{valid:1'b0, sof:1'b0, eof:1'b0, data:~b, port_two:~p2, abort:1'b0, fcs_bad:1'b0};
      end
    end
    // Idle bus shows a flipped byte, so a stale value cannot pass for data
    @(posedge mclk);
    rx_beat <= '{valid:1'b0, sof:1'b0, eof:1'b0, data:~b, port_two:~p2, abort:1'b0, fcs_bad:1'b0};
  endtask
endmodule

/* verif/rxs_frame_status_props.sv */
module rxs_frame_status_props
  import rxs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Watched ports
  input wire rxs_beat_t rx_beat,
  input wire rxs_bus_t host_bus,
  input wire logic [RXS_DATA_W-1:0] rd_data,
  input wire logic irq,
  input wire logic frame_dropped
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic pass_q;
  logic [2:0] mask_q;

  // Shadow of control and mask writes; the checker cannot read them back
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pass_q <= 1'b0;
      mask_q <= 3'h0;
    end else if (host_bus.wr && host_bus.addr == RXS_OFS_CONTROL) begin
      pass_q <= host_bus.wdata[RXS_CTL_PASS_BAD];
    end else if (host_bus.wr && host_bus.addr == RXS_OFS_MASK) begin
      mask_q <= host_bus.wdata[2:0];
    end
  end

  sequence s_stat_rd;
    host_bus.rd && host_bus.addr == RXS_OFS_STATUS;
  endsequence

  AST_RD_IDLE: assert property (!host_bus.rd |=> rd_data == 16'h0000)
    else $error("read data not zero outside a read");
  AST_RSVD: assert property (s_stat_rd |=> rd_data[14:10] == 5'h00 && !rd_data[4])
    else $error("reserved status bits set");
  AST_EMPTY: assert property (s_stat_rd |=> rd_data[15] || rd_data == 16'h0000)
    else $error("status not zero while no frame");
  AST_PORT: assert property (s_stat_rd |=> !rd_data[15] || rd_data[9:8] inside {2'h1, 2'h2})
    else $error("bad port code");
  AST_BCAST: assert property (s_stat_rd ##1 rd_data[7] |-> rd_data[6] && !rd_data[5])
    else $error("broadcast without group bit");
  AST_CLASS: assert property (s_stat_rd ##1 rd_data[15] |-> rd_data[6] != rd_data[5])
    else $error("address class not exclusive");
  AST_RUNT_TYPE: assert property (s_stat_rd ##1 rd_data[1] |-> !rd_data[3])
    else $error("type bit set on runt");
  AST_DROP: assert property (frame_dropped |-> $past(rx_beat.valid && rx_beat.eof) && !$past(pass_q))
    else $error("drop without eof or with pass set");
  AST_IRQ_MASK: assert property (irq |-> $past(mask_q) != 3'h0)
    else $error("irq with all events masked");
endmodule

bind rxs_frame_status rxs_frame_status_props u_props (.mclk(mclk), .arst_n(arst_n), .rx_beat(rx_beat),
  .host_bus(host_bus), .rd_data(rd_data), .irq(irq), .frame_dropped(frame_dropped));

/* verif/rxs_frame_status_test.sv */
module rxs_frame_status_test
  import rxs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  rxs_beat_t rx_beat;
  rxs_bus_t host_bus = '0;
  logic [RXS_DATA_W-1:0] rd_data;
  logic irq;
  logic frame_dropped;
  logic pass_bad = 1'b0;
  int fails = 0;
  int total_checks = 0;

  always #5 mclk = ~mclk;

  rxs_frame_status u_dut (.mclk(mclk), .arst_n(arst_n), .rx_beat(rx_beat), .host_bus(host_bus),
    .rd_data(rd_data), .irq(irq), .frame_dropped(frame_dropped));
  rxs_mac_model u_mac (.mclk(mclk), .rx_beat(rx_beat));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, report and bus tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    host_bus <= '{addr:a, wdata:d, wr:1'b1, rd:1'b0};
    @(posedge mclk);
    host_bus.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    host_bus <= '{addr:a, wdata:16'h0000, wr:1'b0, rd:1'b1};
    @(posedge mclk);
    host_bus.rd <= 1'b0;
    #1 check(rd_data, exp);
  endtask

  function automatic logic [15:0] exp_st(input logic [7:0] da, input logic p2, input int len,
                                         input logic [15:0] typ, input logic ab, input logic fb);
    logic runt;
    runt = ab || len < 64;
    return {1'b1, 5'h00, p2 ? 2'h2 : 2'h1, da == 8'hFF, da[0], !da[0], 1'b0,
            typ > 16'h05DC && !runt, len > 1916, runt, fb};
  endfunction

  // Bad frames vanish unless passing is on; kept ones are popped afterwards
  task automatic frame_case(input logic [7:0] da, input logic p2, input int len, input logic [15:0] typ,
                            input logic ab, input logic fb);
    logic drop;
    drop = (ab || fb || len < 64 || len > 1916) && !pass_bad;
    u_mac.send(da, p2, len, typ, ab, fb, 1'b0);
    #1 check({15'h0000, frame_dropped}, {15'h0000, drop});
    bus_rd(RXS_OFS_STATUS, drop ? 16'h0000 : exp_st(da, p2, len, typ, ab, fb));
    if (!drop) begin
      bus_wr(RXS_OFS_RELEASE, 16'h0001);
    end
  endtask

  task automatic set_pass(input logic p);
    pass_bad = p;
    bus_wr(RXS_OFS_CONTROL, {6'h00, p, 9'h000});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    bus_rd(RXS_OFS_CONTROL, 16'h0000);
    bus_rd(RXS_OFS_STATUS, 16'h0000);
    bus_rd(8'h20, 16'h0000);
    bus_wr(RXS_OFS_STATUS, 16'hFFFF);
    bus_rd(RXS_OFS_STATUS, 16'h0000);
    bus_wr(RXS_OFS_CONTROL, 16'hFFFF);
    bus_rd(RXS_OFS_CONTROL, 16'h0200);
    set_pass(1'b0);
  endtask

  task automatic t_good();
    fork
      u_mac.send(8'hFF, 1'b0, 64, 16'h0800, 1'b0, 1'b0, 1'b1);
      begin
        repeat (30) @(posedge mclk);
        bus_rd(RXS_OFS_STATUS, 16'h0000);
      end
    join
    bus_rd(RXS_OFS_STATUS, exp_st(8'hFF, 1'b0, 64, 16'h0800, 1'b0, 1'b0));
    bus_wr(RXS_OFS_RELEASE, 16'h0001);
    bus_rd(RXS_OFS_STATUS, 16'h0000);
    frame_case(8'h02, 1'b1, 64, 16'h05DC, 1'b0, 1'b0);
    frame_case(8'h01, 1'b1, 1916, 16'h05DD, 1'b0, 1'b0);
  endtask

  task automatic t_bad();
    for (int p = 0; p < 2; p++) begin
      set_pass(p[0]);
      frame_case(8'h02, 1'b0, 64, 16'h0800, 1'b0, 1'b1);
      frame_case(8'h02, 1'b1, 64, 16'h0800, 1'b1, 1'b0);
      frame_case(8'h02, 1'b0, 20, 16'h0800, 1'b0, 1'b0);
      frame_case(8'h02, 1'b0, 1917, 16'h0800, 1'b0, 1'b0);
    end
    set_pass(1'b0);
  endtask

  // Masked event, unmask, clear, then overrun a full queue
  task automatic t_irq();
    // Earlier scenarios left queued and dropped events set; start from a clean slate
    bus_wr(RXS_OFS_EVENT, 16'h0007);
    bus_rd(RXS_OFS_EVENT, 16'h0000);
    u_mac.send(8'h02, 1'b0, 64, 16'h0800, 1'b0, 1'b0, 1'b0);
    @(posedge mclk);
    #1 check({15'h0000, irq}, 16'h0000);
    bus_wr(RXS_OFS_MASK, 16'h0007);
    @(posedge mclk);
    #1 check({15'h0000, irq}, 16'h0001);
    bus_rd(RXS_OFS_EVENT, 16'h0001);
    bus_wr(RXS_OFS_EVENT, 16'h0001);
    @(posedge mclk);
    #1 check({15'h0000, irq}, 16'h0000);
    repeat (4) u_mac.send(8'h02, 1'b0, 64, 16'h0800, 1'b0, 1'b0, 1'b0);
    bus_rd(RXS_OFS_EVENT, 16'h0005);
    check({15'h0000, irq}, 16'h0001);
    repeat (4) bus_wr(RXS_OFS_RELEASE, 16'h0001);
    bus_rd(RXS_OFS_STATUS, 16'h0000);
    bus_wr(RXS_OFS_MASK, 16'h0000);
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    t_good();
    t_bad();
    t_irq();
    end_of_test();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge mclk);
    fails++;
    end_of_test();
  end
endmodule
